// ==== rtl/odsf_pkg.sv ====
// Constants and types shared by the optical module diagnostic flag bank.
// Assumes a 32-bit Avalon-MM slave port and a single 20 MHz system clock.
package odsf_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int READY_TIME_MS = 1000;
    localparam int READY_CYC = READY_TIME_MS * (CLK_HZ / 1000);
    localparam int RESPONSE_TIME_MS = 100;
    localparam int RESPONSE_CYC = RESPONSE_TIME_MS * (CLK_HZ / 1000);
    localparam int READY_CNT_W = 25;

    // ****************************************************************
    // Monitored quantities
    // ****************************************************************
    localparam int NQ = 5;
    localparam int VAL_W = 16;
    localparam int THR_PER_Q = 4;
    localparam int NTHR = NQ * THR_PER_Q;
    localparam int Q_TEMP = 0;
    localparam int THR_HA = 0;
    localparam int THR_LA = 1;
    localparam int THR_HW = 2;
    localparam int THR_LW = 3;
    localparam logic [15:0] THR_HI_RST = 16'hFFFF;
    localparam logic [15:0] THR_LO_RST = 16'h0000;
    localparam logic [15:0] THR_THI_RST = 16'h7FFF;
    localparam logic [15:0] THR_TLO_RST = 16'h8000;

    // ****************************************************************
    // Register indexes (byte address is four times the index)
    // ****************************************************************
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_THR_BASE = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h6E;
    localparam logic [7:0] IDX_ALARM_UP = 8'h70;
    localparam logic [7:0] IDX_ALARM_LO = 8'h71;
    localparam logic [7:0] IDX_WARN_UP = 8'h74;
    localparam logic [7:0] IDX_WARN_LO = 8'h75;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h78;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h79;

    // ****************************************************************
    // Status/control byte fields
    // ****************************************************************
    localparam int BIT_TXDIS_PIN = 7;
    localparam int BIT_SOFT_DIS = 6;
    localparam int BIT_FAULT = 2;
    localparam int BIT_LOS = 1;
    localparam int BIT_NOT_READY = 0;
    localparam int FLAG_LO_RSV_W = 6;

    // ****************************************************************
    // Interrupt status bits
    // ****************************************************************
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_WARN = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_LOS = 3;
    localparam int IRQ_READY = 4;
    localparam int IRQ_W = 5;

    typedef logic [NQ-1:0][VAL_W-1:0] odsf_mon_t;

    typedef struct packed {
        logic tx_disable_pin;
        logic tx_fault;
        logic rx_los;
        logic values_valid;
    } odsf_pins_t;

    typedef enum logic [0:0] {
        ODSF_WAIT,
        ODSF_READY
    } odsf_ready_t;

endpackage

// ==== rtl/odsf_flags.sv ====
// Diagnostic status, soft control and non-latching flag bank of an optical module.
// Assumes pin levels and monitored values arrive synchronous to clk_sys and that
// the monitored values are already scaled into their 16-bit diagnostic form.
//
// Notes on behaviour
// [RULE1] Status bit reads the transmit-disable input pin level, 1 when asserted.
// [RULE2] Host can read and write a software transmit-disable bit.
// [RULE3] Transmitter disabled when software bit 6 or the disable pin is set.
// [RULE4] Status bit reads 1 while the transmit-fault output is asserted.
// [RULE5] Status bit reads 1 while the receive-loss output is asserted.
// [RULE6] Active-low data-ready bit reads 0 once monitored values are valid.
// [RULE7] Soft commands act and status mirrors pins within 100 ms.
// [RULE8] Data ready is signalled no later than 1000 ms after power-up.
// [RULE9] Alarm byte 112: high/low alarms for temp, supply, bias, transmit power.
// [RULE10] Alarm byte 113: receive power high bit 7, low bit 6, rest reserved.
// [RULE11] Warning byte 116 mirrors alarm byte order with warning thresholds.
// [RULE12] Warning byte 117: receive power high bit 7, low bit 6.
// [RULE13] Flags do not latch; they follow the present comparison result.
// [RULE14] Status values never affect transmitter or receiver operation.
// [RULE15] Status and soft command bits live together in byte 110.
// [RULE16] Temperature compares as 16-bit two's complement, 1/256 degree steps.
// [RULE17] Status byte: pin 7, soft 6, fault 2, loss 1, not-ready 0.
// [RULE18] High flag above high threshold, low flag below low threshold.
// [RULE19] Reserved bits read zero; writes to them are ignored.
`timescale 1ns/1ns

module odsf_flags
#(
    parameter int READY_CYC = odsf_pkg::READY_CYC
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Module pins and monitor
    input wire odsf_pkg::odsf_pins_t pins,
    input wire odsf_pkg::odsf_mon_t mon,
    // Transmitter control and interrupt
    output logic tx_disable_q,
    output logic irq_q
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [odsf_pkg::IDX_W-1:0] idx;
    logic req;
    logic wr_fire;
    logic waitreq_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    assign idx = avs_address[9:2];
    assign req = avs_read | avs_write;
    // The master samples waitrequest low at exactly one edge; writes land there
    assign wr_fire = avs_write & ~waitreq_q;
    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = rdata_q;

    // One wait state: low for a single cycle, then high again
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitreq_q <= 1'b1;
        end
        else if (req && waitreq_q)
        begin
            waitreq_q <= 1'b0;
        end
        else
        begin
            waitreq_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Threshold registers
    // ****************************************************************
    logic [odsf_pkg::VAL_W-1:0] thr_q [odsf_pkg::NTHR];
    logic [odsf_pkg::NQ-1:0] alarm_hi;
    logic [odsf_pkg::NQ-1:0] alarm_lo;
    logic [odsf_pkg::NQ-1:0] warn_hi;
    logic [odsf_pkg::NQ-1:0] warn_lo;

    // Signed compare only for temperature; other quantities are unsigned
    function automatic logic above(logic [15:0] a, logic [15:0] b, logic sgn);
        above = sgn ? ($signed(a) > $signed(b)) : (a > b);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < odsf_pkg::NTHR; gi++)
        begin : g_thr
            localparam logic [7:0] MY_IDX = odsf_pkg::IDX_THR_BASE + 8'(gi);
            localparam bit IS_HI = ((gi % odsf_pkg::THR_PER_Q) == odsf_pkg::THR_HA)
                || ((gi % odsf_pkg::THR_PER_Q) == odsf_pkg::THR_HW);
            localparam bit IS_TEMP = (gi / odsf_pkg::THR_PER_Q) == odsf_pkg::Q_TEMP;
            localparam logic [15:0] RST = IS_TEMP
                ? (IS_HI ? odsf_pkg::THR_THI_RST : odsf_pkg::THR_TLO_RST)
                : (IS_HI ? odsf_pkg::THR_HI_RST : odsf_pkg::THR_LO_RST);
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    thr_q[gi] <= RST;
                end
                else if (wr_fire && idx == MY_IDX)
                begin
                    if (avs_byteenable[0])
                    begin
                        thr_q[gi][7:0] <= avs_writedata[7:0];
                    end
                    if (avs_byteenable[1])
                    begin
                        thr_q[gi][15:8] <= avs_writedata[15:8];
                    end
                end
            end
        end

        for (gi = 0; gi < odsf_pkg::NQ; gi++)
        begin : g_cmp
            localparam int B = gi * odsf_pkg::THR_PER_Q;
            localparam bit SGN = (gi == odsf_pkg::Q_TEMP);
            // [RULE16] signed temperature compare
            // [RULE18] above high, below low
            assign alarm_hi[gi] = above(mon[gi], thr_q[B + odsf_pkg::THR_HA], SGN);
            assign alarm_lo[gi] = above(thr_q[B + odsf_pkg::THR_LA], mon[gi], SGN);
            assign warn_hi[gi] = above(mon[gi], thr_q[B + odsf_pkg::THR_HW], SGN);
            assign warn_lo[gi] = above(thr_q[B + odsf_pkg::THR_LW], mon[gi], SGN);
        end
    endgenerate

    // ****************************************************************
    // Flag bytes
    // ****************************************************************
    logic [2*odsf_pkg::NQ-1:0] alarm_d;
    logic [2*odsf_pkg::NQ-1:0] alarm_q;
    logic [2*odsf_pkg::NQ-1:0] warn_d;
    logic [2*odsf_pkg::NQ-1:0] warn_q;

    // Quantity 0 lands in the top pair of bits, high above low
    always_comb
    begin
        for (int q = 0; q < odsf_pkg::NQ; q++)
        begin
            alarm_d[2*(odsf_pkg::NQ-1-q) + 1] = alarm_hi[q];
            alarm_d[2*(odsf_pkg::NQ-1-q)] = alarm_lo[q];
            warn_d[2*(odsf_pkg::NQ-1-q) + 1] = warn_hi[q];
            warn_d[2*(odsf_pkg::NQ-1-q)] = warn_lo[q];
        end
    end

    // [RULE13] no latching, refreshed
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_q <= '0;
            warn_q <= '0;
        end
        else
        begin
            alarm_q <= alarm_d;
            warn_q <= warn_d;
        end
    end

    // ****************************************************************
    // Status/control byte
    // ****************************************************************
    logic soft_dis_q;
    odsf_pkg::odsf_pins_t pins_q;
    logic [7:0] status_byte;

    // [RULE2] software disable bit
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_dis_q <= 1'b0;
        end
        else if (wr_fire && idx == odsf_pkg::IDX_STATUS && avs_byteenable[0])
        begin
            soft_dis_q <= avs_writedata[odsf_pkg::BIT_SOFT_DIS];
        end
    end

    // [RULE7] pins mirrored each cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_q <= '0;
        end
        else
        begin
            pins_q <= pins;
        end
    end

    // [RULE3] pin ORed with soft bit
    // [RULE14] driven from control only
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_disable_q <= 1'b0;
        end
        else
        begin
            tx_disable_q <= pins.tx_disable_pin | soft_dis_q;
        end
    end

    // ****************************************************************
    // Data-ready sequencing
    // ****************************************************************
    odsf_pkg::odsf_ready_t rdy_state_q;
    logic [odsf_pkg::READY_CNT_W-1:0] rdy_cnt_q;
    logic rdy_timeout;

    assign rdy_timeout = rdy_cnt_q >= odsf_pkg::READY_CNT_W'(READY_CYC - 1);

    // Timeout forces ready so the host is never left waiting past the limit
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdy_cnt_q <= '0;
        end
        else if (rdy_state_q == odsf_pkg::ODSF_WAIT && !rdy_timeout)
        begin
            rdy_cnt_q <= rdy_cnt_q + 1'b1;
        end
    end

    // [RULE8] ready within limit
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdy_state_q <= odsf_pkg::ODSF_WAIT;
        end
        else
        begin
            unique case (rdy_state_q)
                odsf_pkg::ODSF_WAIT:
                begin
                    if (pins.values_valid || rdy_timeout)
                    begin
                        rdy_state_q <= odsf_pkg::ODSF_READY;
                    end
                end
                odsf_pkg::ODSF_READY:
                begin
                    rdy_state_q <= odsf_pkg::ODSF_READY;
                end
            endcase
        end
    end

    // [RULE15] one byte for status and command
    always_comb
    begin
        status_byte = '0;
        // [RULE1] pin level
        status_byte[odsf_pkg::BIT_TXDIS_PIN] = pins_q.tx_disable_pin;
        // [RULE17] field positions
        status_byte[odsf_pkg::BIT_SOFT_DIS] = soft_dis_q;
        // [RULE4] fault level
        status_byte[odsf_pkg::BIT_FAULT] = pins_q.tx_fault;
        // [RULE5] loss level
        status_byte[odsf_pkg::BIT_LOS] = pins_q.rx_los;
        // [RULE6] active-low ready
        status_byte[odsf_pkg::BIT_NOT_READY] = (rdy_state_q != odsf_pkg::ODSF_READY);
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [odsf_pkg::IRQ_W-1:0] irq_ev;
    logic [odsf_pkg::IRQ_W-1:0] irq_stat_q;
    logic [odsf_pkg::IRQ_W-1:0] irq_stat_d;
    logic [odsf_pkg::IRQ_W-1:0] irq_mask_q;
    logic [odsf_pkg::IRQ_W-1:0] irq_clr;
    logic rdy_prev_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdy_prev_q <= 1'b0;
        end
        else
        begin
            rdy_prev_q <= (rdy_state_q == odsf_pkg::ODSF_READY);
        end
    end

    // Events are rising edges so a standing flag does not re-raise after a clear
    always_comb
    begin
        irq_ev = '0;
        irq_ev[odsf_pkg::IRQ_ALARM] = |(alarm_d & ~alarm_q);
        irq_ev[odsf_pkg::IRQ_WARN] = |(warn_d & ~warn_q);
        irq_ev[odsf_pkg::IRQ_FAULT] = pins.tx_fault & ~pins_q.tx_fault;
        irq_ev[odsf_pkg::IRQ_LOS] = pins.rx_los & ~pins_q.rx_los;
        irq_ev[odsf_pkg::IRQ_READY] = (rdy_state_q == odsf_pkg::ODSF_READY) & ~rdy_prev_q;
    end

    assign irq_clr = (wr_fire && idx == odsf_pkg::IDX_IRQ_STAT && avs_byteenable[0])
        ? avs_writedata[odsf_pkg::IRQ_W-1:0] : '0;
    // A new event beats a clear in the same cycle
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_mask_q <= '0;
        end
        else if (wr_fire && idx == odsf_pkg::IDX_IRQ_MASK && avs_byteenable[0])
        begin
            irq_mask_q <= avs_writedata[odsf_pkg::IRQ_W-1:0];
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb
    begin
        rdata_d = '0;
        if (idx < odsf_pkg::IDX_THR_BASE + 8'(odsf_pkg::NTHR))
        begin
            rdata_d[15:0] = thr_q[5'(idx - odsf_pkg::IDX_THR_BASE)];
        end
        else
        begin
            unique case (idx)
                odsf_pkg::IDX_STATUS: rdata_d[7:0] = status_byte;
                // [RULE9] alarm upper byte
                odsf_pkg::IDX_ALARM_UP: rdata_d[7:0] = alarm_q[9:2];
                // [RULE10] [RULE19] reserved low bits zero
                odsf_pkg::IDX_ALARM_LO:
                    rdata_d[7:0] = {alarm_q[1:0], {odsf_pkg::FLAG_LO_RSV_W{1'b0}}};
                // [RULE11] warning upper byte
                odsf_pkg::IDX_WARN_UP: rdata_d[7:0] = warn_q[9:2];
                // [RULE12] warning lower byte
                odsf_pkg::IDX_WARN_LO:
                    rdata_d[7:0] = {warn_q[1:0], {odsf_pkg::FLAG_LO_RSV_W{1'b0}}};
                odsf_pkg::IDX_IRQ_STAT: rdata_d[odsf_pkg::IRQ_W-1:0] = irq_stat_q;
                odsf_pkg::IDX_IRQ_MASK: rdata_d[odsf_pkg::IRQ_W-1:0] = irq_mask_q;
                default: rdata_d = '0;
            endcase
        end
    end

    // Captured as waitrequest drops, so it stands at the sampling edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= '0;
        end
        else if (avs_read && waitreq_q)
        begin
            rdata_q <= rdata_d;
        end
    end

endmodule

// ==== dv/odsf_flags_properties.sv ====
// Port-level assertions for the diagnostic flag bank.
// Assumes one clock domain and the one-wait-cycle Avalon timing of the block.
`timescale 1ns/1ns
module odsf_flags_props
#(
    parameter int READY_CYC = 50
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins, monitor and outputs
    input wire odsf_pkg::odsf_pins_t pins,
    input wire odsf_pkg::odsf_mon_t mon,
    input wire logic tx_disable_q,
    input wire logic irq_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_ack(logic [7:0] idx);
        avs_read && !avs_waitrequest && avs_address[9:2] == idx;
    endsequence
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // Three cycles with no write and a steady pin: nothing may move the output
    sequence s_quiet;
        (!avs_write && $stable(pins.tx_disable_pin)) [*3];
    endsequence

    property p_rsv_alarm;
        s_ack(odsf_pkg::IDX_ALARM_LO) |-> avs_readdata[5:0] == 6'h00;
    endproperty
    property p_rsv_warn;
        s_ack(odsf_pkg::IDX_WARN_LO) |-> avs_readdata[5:0] == 6'h00;
    endproperty
    property p_rsv_status;
        s_ack(odsf_pkg::IDX_STATUS) |-> avs_readdata[5:3] == 3'h0 && avs_readdata[31:8] == 24'h0;
    endproperty
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_answer;
        s_taken |-> ##[1:2] !avs_waitrequest;
    endproperty
    property p_idle;
        !(avs_read || avs_write) [*2] |=> avs_waitrequest;
    endproperty
    property p_tx_pin;
        pins.tx_disable_pin [*2] |=> tx_disable_q;
    endproperty
    property p_quiet;
        s_quiet |=> $stable(tx_disable_q);
    endproperty
    property p_soft_on;
        avs_write && !avs_waitrequest && avs_address[9:2] == odsf_pkg::IDX_STATUS
            && avs_byteenable[0] && avs_writedata[6] |-> ##[1:3] tx_disable_q;
    endproperty

    a_rsv_alarm:
        assert property (p_rsv_alarm) else $error("reserved alarm bits not zero");
    a_rsv_warn:
        assert property (p_rsv_warn) else $error("reserved warning bits not zero");
    a_rsv_status:
        assert property (p_rsv_status) else $error("reserved status bits not zero");
    a_wait_one:
        assert property (p_wait_one) else $error("waitrequest low too long");
    a_answer:
        assert property (p_answer) else $error("request not answered");
    a_idle:
        assert property (p_idle) else $error("waitrequest low without request");
    a_tx_pin:
        assert property (p_tx_pin) else $error("pin did not disable transmitter");
    a_quiet:
        assert property (p_quiet) else $error("transmit disable moved without cause");
    a_soft_on:
        assert property (p_soft_on) else $error("soft disable not applied");
endmodule

// ==== dv/odsf_host.sv ====
// Host controller model: an Avalon-MM master reaching the management registers.
// Assumes the caller enters a transfer right after a rising clock edge.
`timescale 1ns/1ns
module odsf_host
(
    // Clock
    input wire logic clk_sys,
    // Avalon-MM master
    output logic [9:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial
    begin
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end

    task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] q);
        // Idle edge first so a released strobe is never raised in the same step
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= !we;
        @(posedge clk_sys);
        while (avs_waitrequest)
            @(posedge clk_sys);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_writedata <= ~d;
    endtask
endmodule

// ==== dv/odsf_flags_tb.sv ====
// Self-checking bench of the diagnostic flag bank with a host master model.
// Assumes a shortened readiness timeout through the READY_CYC parameter.
`timescale 1ns/1ns
module odsf_flags_tb;
    localparam int READY_CYC = 50;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    odsf_pkg::odsf_pins_t pins = '0;
    odsf_pkg::odsf_mon_t mon = '0;
    logic tx_disable_q;
    logic irq_q;
    logic [31:0] rdat;
    int error_cnt = 0;
    int num_checks = 0;

    always #25 clk_sys = ~clk_sys;

    odsf_flags #(.READY_CYC(READY_CYC)) i_odsf_flags (.clk_sys(clk_sys), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
        .mon(mon), .tx_disable_q(tx_disable_q), .irq_q(irq_q));
    odsf_host i_odsf_host (.clk_sys(clk_sys), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
            error_cnt++;
        end
    endtask
    task automatic wr(logic [7:0] idx, logic [31:0] d);
        i_odsf_host.xfer(1'b1, idx, d, rdat);
    endtask
    task automatic rdchk(string what, logic [7:0] idx, logic [31:0] exp);
        i_odsf_host.xfer(1'b0, idx, 32'h0, rdat);
        chk(what, exp, rdat);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_regs;
        rdchk("status", odsf_pkg::IDX_STATUS, 32'h01);
        rdchk("temp_hi_thr", 8'h00, 32'h7FFF);
        rdchk("temp_lo_thr", 8'h01, 32'h8000);
        rdchk("vcc_hi_thr", 8'h04, 32'hFFFF);
        wr(8'h50, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'h50, 32'h0);
        wr(odsf_pkg::IDX_ALARM_UP, 32'hFF);
        rdchk("alarm_ro", odsf_pkg::IDX_ALARM_UP, 32'h0);
        $display("t_reset_regs done");
    endtask
    task automatic t_ready;
        do_reset;
        rdchk("not_ready", odsf_pkg::IDX_STATUS, 32'h01);
        repeat (READY_CYC) @(posedge clk_sys);
        rdchk("ready_timeout", odsf_pkg::IDX_STATUS, 32'h00);
        pins.values_valid <= 1'b1;
        do_reset;
        repeat (2) @(posedge clk_sys);
        rdchk("ready_valid", odsf_pkg::IDX_STATUS, 32'h00);
        $display("t_ready done");
    endtask
    task automatic t_status;
        pins.tx_disable_pin <= 1'b1;
        pins.rx_los <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk("status_pin_los", odsf_pkg::IDX_STATUS, 32'h82);
        chk("tx_dis_pin", 32'h1, {31'h0, tx_disable_q});
        pins.tx_disable_pin <= 1'b0;
        pins.rx_los <= 1'b0;
        pins.tx_fault <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk("status_fault", odsf_pkg::IDX_STATUS, 32'h04);
        chk("tx_dis_off", 32'h0, {31'h0, tx_disable_q});
        wr(odsf_pkg::IDX_STATUS, 32'hFF);
        rdchk("status_soft", odsf_pkg::IDX_STATUS, 32'h44);
        chk("tx_dis_soft", 32'h1, {31'h0, tx_disable_q});
        wr(odsf_pkg::IDX_STATUS, 32'h00);
        repeat (2) @(posedge clk_sys);
        chk("tx_dis_clear", 32'h0, {31'h0, tx_disable_q});
        $display("t_status done");
    endtask
    task automatic t_flags;
        wr(8'h00, 32'h1900);
        wr(8'h01, 32'hFB00);
        wr(8'h06, 32'h8000);
        wr(8'h09, 32'h0200);
        wr(8'h0C, 32'h0300);
        wr(8'h10, 32'h1000);
        wr(8'h13, 32'h0100);
        // Negative temperature would read as a high alarm if compared unsigned
        mon <= {16'h2000, 16'h0400, 16'h0100, 16'h9000, 16'hF600};
        repeat (3) @(posedge clk_sys);
        rdchk("alarm_up", odsf_pkg::IDX_ALARM_UP, 32'h46);
        rdchk("alarm_lo", odsf_pkg::IDX_ALARM_LO, 32'h80);
        rdchk("warn_up", odsf_pkg::IDX_WARN_UP, 32'h20);
        rdchk("warn_lo", odsf_pkg::IDX_WARN_LO, 32'h00);
        mon <= {16'h0050, 16'h0300, 16'h0200, 16'h8000, 16'h1900};
        repeat (3) @(posedge clk_sys);
        rdchk("alarm_up_eq", odsf_pkg::IDX_ALARM_UP, 32'h00);
        rdchk("alarm_lo_clr", odsf_pkg::IDX_ALARM_LO, 32'h00);
        rdchk("warn_up_eq", odsf_pkg::IDX_WARN_UP, 32'h00);
        rdchk("warn_lo_rx", odsf_pkg::IDX_WARN_LO, 32'h40);
        $display("t_flags done");
    endtask
    task automatic t_irq;
        pins.tx_fault <= 1'b0;
        wr(odsf_pkg::IDX_IRQ_MASK, 32'h04);
        wr(odsf_pkg::IDX_IRQ_STAT, 32'h1F);
        rdchk("irq_stat_clr", odsf_pkg::IDX_IRQ_STAT, 32'h0);
        chk("irq_idle", 32'h0, {31'h0, irq_q});
        pins.tx_fault <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk("irq_stat_fault", odsf_pkg::IDX_IRQ_STAT, 32'h04);
        chk("irq_set", 32'h1, {31'h0, irq_q});
        wr(odsf_pkg::IDX_IRQ_MASK, 32'h00);
        repeat (2) @(posedge clk_sys);
        chk("irq_masked", 32'h0, {31'h0, irq_q});
        wr(odsf_pkg::IDX_IRQ_MASK, 32'h04);
        repeat (2) @(posedge clk_sys);
        chk("irq_unmasked", 32'h1, {31'h0, irq_q});
        wr(odsf_pkg::IDX_IRQ_STAT, 32'h04);
        repeat (2) @(posedge clk_sys);
        chk("irq_w1c", 32'h0, {31'h0, irq_q});
        $display("t_irq done");
    endtask

    initial
    begin
        do_reset;
        t_reset_regs;
        t_ready;
        t_status;
        t_flags;
        t_irq;
        test_done;
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        test_done;
    end
endmodule

bind odsf_flags odsf_flags_props #(.READY_CYC(READY_CYC)) i_odsf_flags_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
    .mon(mon), .tx_disable_q(tx_disable_q), .irq_q(irq_q));
